// ==== gdio_port.sv ====
// General digital I/O port: AHB-Lite register slave, pin drivers with
// pull-up control, toggle-on-write input location, input synchroniser.
// Assumes one AHB-Lite master, single word transfers, pads outside.
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none

module gdio_port
  import gdio_pkg::*;
#(
  parameter int PIN_W = gdio_pkg::PIN_W_DEF
) (
  // Clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [gdio_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [gdio_pkg::DATA_W-1:0] hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [gdio_pkg::DATA_W-1:0] hrdata,
  // Pads
  input  wire logic [PIN_W-1:0]            pad_in,
  output logic      [PIN_W-1:0]            pad_out,
  output logic      [PIN_W-1:0]            pad_oe_n,
  output logic      [PIN_W-1:0]            pad_pullup_en,
  // Sleep controller
  input  wire logic                        sleep_clamp,
  input  wire logic [PIN_W-1:0]            wake_pin_en
);
  import gdio_pkg::*;

  // ==========================================================================
  // Address phase capture
  // ==========================================================================
  logic             addr_take;
  logic             dp_wr_r;
  logic [OFS_W-1:0] dp_ofs_r;
  logic [PIN_W-1:0] wdata;

  assign addr_take = hsel & htrans[HTRANS_ACT_BIT] & hready;
  assign wdata     = hwdata[PIN_W-1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r  <= RST_BIT;
      dp_ofs_r <= {OFS_W{RST_BIT}};
    end else begin
      dp_wr_r  <= addr_take & hwrite;
      dp_ofs_r <= haddr[OFS_W-1:0];
    end
  end

  // ==========================================================================
  // Write decode
  // ==========================================================================
  logic wr_out;
  logic wr_dir;
  logic wr_in;
  logic wr_ctrl;
  logic wr_oset;
  logic wr_oclr;
  logic wr_dset;
  logic wr_dclr;

  // Eight separate locations per port
  assign wr_out  = dp_wr_r & (dp_ofs_r == OFS_OUT);
  assign wr_dir  = dp_wr_r & (dp_ofs_r == OFS_DIR);
  assign wr_in   = dp_wr_r & (dp_ofs_r == OFS_IN);
  assign wr_ctrl = dp_wr_r & (dp_ofs_r == OFS_CTRL);
  assign wr_oset = dp_wr_r & (dp_ofs_r == OFS_OUT_SET);
  assign wr_oclr = dp_wr_r & (dp_ofs_r == OFS_OUT_CLR);
  assign wr_dset = dp_wr_r & (dp_ofs_r == OFS_DIR_SET);
  assign wr_dclr = dp_wr_r & (dp_ofs_r == OFS_DIR_CLR);

  // ==========================================================================
  // Port registers
  // ==========================================================================
  logic [PIN_W-1:0] out_r;
  logic [PIN_W-1:0] out_nxt;
  logic [PIN_W-1:0] dir_r;
  logic [PIN_W-1:0] dir_nxt;
  logic             pu_dis_r;
  logic             pu_dis_nxt;

  // Output bits: plain write, toggle via input location, set, clear
  assign out_nxt = wr_out  ? wdata :
                   wr_in   ? (out_r ^ wdata) :
                   wr_oset ? (out_r | wdata) :
                   wr_oclr ? (out_r & ~wdata) :
                   out_r;

  // Direction bits; input location writes never reach them
  assign dir_nxt = wr_dir  ? wdata :
                   wr_dset ? (dir_r | wdata) :
                   wr_dclr ? (dir_r & ~wdata) :
                   dir_r;

  assign pu_dis_nxt = wr_ctrl ? hwdata[CTRL_PU_DIS_BIT] : pu_dis_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_r <= {PIN_W{RST_BIT}};
      dir_r <= {PIN_W{RST_BIT}};
      pu_dis_r <= RST_BIT;
    end else begin
      out_r <= out_nxt;
      dir_r <= dir_nxt;
      pu_dis_r <= pu_dis_nxt;
    end
  end

  // ==========================================================================
  // Pin control
  // ==========================================================================
  // Each pin depends only on its own bits and the shared pull-up disable bit, so alternate use of others is harmless
  logic [PIN_W-1:0] oe_n_nxt;
  logic [PIN_W-1:0] pullup_nxt;
  logic [PIN_W-1:0] pad_out_r;
  logic [PIN_W-1:0] pad_oe_n_r;
  logic [PIN_W-1:0] pad_pullup_r;

  assign oe_n_nxt   = ~dir_nxt;
  assign pullup_nxt = ~dir_nxt & out_nxt & {PIN_W{~pu_dis_nxt}};

  // Pad flops load with the registers so pins follow in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out_r    <= {PIN_W{RST_BIT}};
      pad_oe_n_r   <= {PIN_W{HIZ_OE_N}};
      pad_pullup_r <= {PIN_W{RST_BIT}};
    end else begin
      pad_out_r    <= out_nxt;
      pad_oe_n_r   <= oe_n_nxt;
      pad_pullup_r <= pullup_nxt;
    end
  end

  assign pad_out       = pad_out_r;
  assign pad_oe_n      = pad_oe_n_r;
  assign pad_pullup_en = pad_pullup_r;

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  gdio_sync_if #(.PIN_W(PIN_W)) sif ();

  logic [PIN_W-1:0] pin_in_bits;

  // Wake-enabled pins stay live in deep sleep
  assign sif.pad_level  = pad_in;
  assign sif.clamp_mask = {PIN_W{sleep_clamp}} & ~wake_pin_en;
  assign pin_in_bits    = sif.in_bits;

  gdio_sync_bank #(
    .PIN_W   (PIN_W)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (sif.bank)
  );

  // ==========================================================================
  // Read path
  // ==========================================================================
  localparam int PAD_W = DATA_W - PIN_W;

  logic [OFS_W-1:0]  rd_ofs;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] hrdata_r;
  logic              hreadyout_r;
  logic              hresp_r;

  assign rd_ofs = haddr[OFS_W-1:0];

  // Next values so a read right after a write sees the new contents
  assign rd_val =
    (rd_ofs == OFS_OUT)  ? {{PAD_W{FILL_BIT}}, out_nxt} :
    (rd_ofs == OFS_DIR)  ? {{PAD_W{FILL_BIT}}, dir_nxt} :
    (rd_ofs == OFS_IN)   ? {{PAD_W{FILL_BIT}}, pin_in_bits} :
    (rd_ofs == OFS_CTRL) ? {{(DATA_W-1){FILL_BIT}}, pu_dis_nxt} :
    {DATA_W{FILL_BIT}};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r    <= {DATA_W{FILL_BIT}};
      hreadyout_r <= READY_HIGH;
      hresp_r     <= RESP_OKAY;
    end else begin
      hrdata_r    <= (addr_take & ~hwrite) ? rd_val : {DATA_W{FILL_BIT}};
      hreadyout_r <= READY_HIGH;
      hresp_r     <= RESP_OKAY;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_in_write;
    dp_wr_r && (dp_ofs_r == OFS_IN);
  endsequence

  sequence s_out_set;
    dp_wr_r && (dp_ofs_r == OFS_OUT_SET);
  endsequence

  sequence s_dir_clr;
    dp_wr_r && (dp_ofs_r == OFS_DIR_CLR);
  endsequence

  chk_direction_drive: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pad_oe_n == ~dir_r)
    else $error("Output enable does not follow direction bits");

  chk_pullup_on_input: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pad_pullup_en ^ (~dir_r & out_r & {PIN_W{~pu_dis_r}})) == {PIN_W{RST_BIT}})
    else $error("Pull-up missing on input pin with output bit set");

  chk_pullup_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (pad_pullup_en & (dir_r | ~out_r)) == {PIN_W{RST_BIT}})
    else $error("Pull-up on while output bit low or pin driven");

  chk_reset_hiz: assert property (
    @(posedge hclk)
    !hresetn |-> (&pad_oe_n) && (pad_pullup_en == {PIN_W{RST_BIT}}))
    else $error("Pin not high impedance during reset");

  chk_drive_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((pad_out ^ out_r) & ~pad_oe_n) == {PIN_W{RST_BIT}})
    else $error("Driven pin level differs from output bit");

  chk_toggle_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_in_write |=> out_r == ($past(out_r) ^ $past(wdata)))
    else $error("Input location write did not toggle output bits");

  chk_input_no_store: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_in_write |=> $stable(dir_r) && $stable(pu_dis_r))
    else $error("Input location write changed stored state");

  chk_pullup_disable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pu_dis_r |-> pad_pullup_en == {PIN_W{RST_BIT}})
    else $error("Pull-up active while globally disabled");

  chk_set_only_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_out_set |=> (out_r == ($past(out_r) | $past(wdata))) && $stable(dir_r))
    else $error("Bit set disturbed other bits");

  chk_clear_only_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_dir_clr |=> (dir_r == ($past(dir_r) & ~$past(wdata))) && $stable(out_r))
    else $error("Bit clear disturbed other bits");

  chk_reset_zero: assert property (
    @(posedge hclk)
    $rose(hresetn) |-> (out_r == {PIN_W{RST_BIT}}) && (dir_r == {PIN_W{RST_BIT}}))
    else $error("Port bits not zero after reset");

endmodule

`default_nettype wire

// ==== gdio_pkg.sv ====
// Constants for the general digital I/O port: register map, field
// positions, reset values and bus encodings.
// Assumes a 32-bit AHB-Lite slave port and a 125 MHz system clock.
`default_nettype none

package gdio_pkg;

  // ==========================================================================
  // Port shape
  // ==========================================================================
  localparam int          PIN_W_DEF    = 6;
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 32;
  localparam int          OFS_W        = 8;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0]  OFS_OUT      = 8'h00;
  localparam logic [7:0]  OFS_DIR      = 8'h04;
  localparam logic [7:0]  OFS_IN       = 8'h08;
  localparam logic [7:0]  OFS_CTRL     = 8'h0C;
  localparam logic [7:0]  OFS_OUT_SET  = 8'h10;
  localparam logic [7:0]  OFS_OUT_CLR  = 8'h14;
  localparam logic [7:0]  OFS_DIR_SET  = 8'h18;
  localparam logic [7:0]  OFS_DIR_CLR  = 8'h1C;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam int          CTRL_PU_DIS_BIT = 0;
  localparam logic        RST_BIT      = 1'b0;
  localparam logic        HIZ_OE_N     = 1'b1;
  localparam logic        FILL_BIT     = 1'b0;

  // ==========================================================================
  // Bus encodings
  // ==========================================================================
  localparam int          HTRANS_ACT_BIT = 1;
  localparam logic        RESP_OKAY      = 1'b0;
  localparam logic        READY_HIGH     = 1'b1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          SYNC_LAG_NS    = 8;
  localparam int          SYNC_LAG_CYC   = (SYNC_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// ==== gdio_sync_if.sv ====
// Interface between the port core and its input synchroniser bank.
// Assumes both ends run on the same system clock.
`default_nettype none

interface gdio_sync_if #(
  parameter int PIN_W = 6
);
  logic [PIN_W-1:0] pad_level;
  logic [PIN_W-1:0] clamp_mask;
  logic [PIN_W-1:0] in_bits;

  modport core (
    output pad_level,
    output clamp_mask,
    input  in_bits
  );

  modport bank (
    input  pad_level,
    input  clamp_mask,
    output in_bits
  );
endinterface

`default_nettype wire

// ==== gdio_sync_bank.sv ====
// Input synchroniser bank: per pin a clamp gate, a latch open while the
// clock is high, and a flop that takes the held value at the rising edge.
// Assumes the pad level is asynchronous to hclk.
`default_nettype none

module gdio_sync_bank #(
  parameter int PIN_W = 6
) (
  // Clock and reset
  input wire logic  hclk,
  input wire logic  hresetn,
  // Core side
  gdio_sync_if.bank sif
);
  import gdio_pkg::*;

  logic [PIN_W-1:0] gated_level;
  logic [PIN_W-1:0] latch_q;
  logic [PIN_W-1:0] in_r;

  // Clamp to ground ahead of the synchroniser
  assign gated_level = sif.pad_level & ~sif.clamp_mask;

  // Transparent while clock high, holds while low
  always_latch begin
    if (hclk) begin
      latch_q <= gated_level;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_r <= {PIN_W{RST_BIT}};
    end else begin
      in_r <= latch_q;
    end
  end

  assign sif.in_bits = in_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_clamp_to_ground: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sif.in_bits & $past(sif.clamp_mask)) == {PIN_W{RST_BIT}})
    else $error("Clamped pin reached the input bit");

  chk_sync_one_cycle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($past(sif.pad_level) == $past(sif.pad_level, 2)) && $past(hresetn, 2)
    |-> sif.in_bits == ($past(sif.pad_level) & ~$past(sif.clamp_mask)))
    else $error("Input bit lag differs from one clock");

endmodule

`default_nettype wire

// ==== gdio_pad_model.sv ====
// Partner model: external circuitry on the port pins, one optional driver a pin.
// Assumes the design's pad outputs; the bench owns the external drivers.
`default_nettype none

module gdio_pad_model #(
  parameter int PIN_W = 6
) (
  // Clock
  input  wire logic             hclk,
  // Design pad side
  input  wire logic [PIN_W-1:0] pad_out,
  input  wire logic [PIN_W-1:0] pad_oe_n,
  input  wire logic [PIN_W-1:0] pad_pullup_en,
  // External drivers
  input  wire logic [PIN_W-1:0] ext_en,
  input  wire logic [PIN_W-1:0] ext_val,
  // Resolved pin level
  output logic      [PIN_W-1:0] pad_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Pin resolution
  // ==========================================================================
  // Undriven pins wander every cycle, so a stale value never passes
  logic [PIN_W-1:0] float_r = '0;

  always @(posedge hclk) begin
    float_r <= ~float_r;
  end

  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (!pad_oe_n[i]) begin
        pad_level[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_level[i] = ext_val[i];
      end else if (pad_pullup_en[i]) begin
        pad_level[i] = 1'b1;
      end else begin
        pad_level[i] = float_r[i];
      end
    end
  end
endmodule

`default_nettype wire

// ==== general_digital_io_port_tb_top.sv ====
// Testbench for the general digital I/O port: AHB-Lite master tasks,
// reference model of the registers and pins, random register traffic.
// Assumes gdio_pkg, gdio_sync_if, gdio_sync_bank, gdio_port and the pad model.
`default_nettype none

module general_digital_io_port_tb_top import gdio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int W = PIN_W_DEF;

  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic                hwrite;
  logic                hreadyout;
  logic                hresp;
  logic                sleep_clamp;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [ADDR_W-1:0]   haddr;
  logic [DATA_W-1:0]   hwdata;
  logic [DATA_W-1:0]   hrdata;
  logic [W-1:0]        pad_in;
  logic [W-1:0]        pad_out;
  logic [W-1:0]        pad_oe_n;
  logic [W-1:0]        pad_pullup_en;
  logic [W-1:0]        wake_pin_en;
  logic [W-1:0]        ext_en;
  logic [W-1:0]        ext_val;
  logic [W-1:0]        m_out;
  logic [W-1:0]        m_dir;
  logic                m_pu_dis;
  logic [31:0]         seed;
  logic [7:0]          ofs [8];
  int                  failures;
  int                  n_tests;
  int                  cycles;

  gdio_port #(.PIN_W(W)) gdio_port_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
    .sleep_clamp(sleep_clamp), .wake_pin_en(wake_pin_en)
  );

  gdio_pad_model #(.PIN_W(W)) gdio_pad_model_i (
    .hclk(hclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
    .pad_level(pad_in)
  );

  // ==========================================================================
  // Clock, timeout and verdict
  // ==========================================================================
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic test_done();
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
    check(32'(hresp), 32'(RESP_OKAY));
  endtask

  function automatic logic [W-1:0] pu_exp();
    return ~m_dir & m_out & {W{~m_pu_dis}};
  endfunction

  task automatic check_pads();
    logic [W-1:0] e;
    e = ~m_dir;
    check(32'(pad_oe_n), 32'(e));
    check(32'(pad_out & m_dir), 32'(m_out & m_dir));
    e = pu_exp();
    check(32'(pad_pullup_en), 32'(e));
  endtask

  task automatic check_regs();
    logic [W-1:0] lvl;
    logic [W-1:0] known;
    logic [W-1:0] clamp;
    logic [31:0]  d;
    bus_rd(OFS_OUT, d);
    check(d, 32'(m_out));
    bus_rd(OFS_DIR, d);
    check(d, 32'(m_dir));
    clamp = {W{sleep_clamp}} & ~wake_pin_en;
    lvl   = (m_dir & m_out) | (~m_dir & ext_en & ext_val) | (~m_dir & ~ext_en & pu_exp());
    known = m_dir | ext_en | pu_exp() | clamp;
    lvl   = lvl & ~clamp & known;
    bus_rd(OFS_IN, d);
    known = d[W-1:0] & known;
    check(32'(known), 32'(lvl));
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] d;
    logic [W-1:0] dv;
    int op;
    hresetn = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    sleep_clamp = 1'b0;
    wake_pin_en = '0;
    ext_en = '0;
    ext_val = '0;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    seed = 32'h000007B8;
    m_out = '0;
    m_dir = '0;
    m_pu_dis = 1'b0;
    ofs = '{OFS_OUT, OFS_DIR, OFS_IN, OFS_CTRL, OFS_OUT_SET, OFS_OUT_CLR,
            OFS_DIR_SET, OFS_DIR_CLR};
    // Real falling edge before the first clock, so pad flops start known
    #1 hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    check_pads();
    hresetn <= 1'b1;
    check_regs();
    bus_wr(8'h20, 32'hFFFFFFFF);
    bus_rd(8'h20, d);
    check(d, 32'h00000000);
    #1;
    check_pads();
    for (int i = 0; i < 200; i++) begin
      @(posedge hclk);
      d = rnd();
      ext_en <= d[W-1:0];
      d = rnd();
      ext_val <= d[W-1:0];
      sleep_clamp <= (rnd() % 4 == 0);
      d = rnd();
      wake_pin_en <= d[W-1:0];
      op = int'(rnd() % 8);
      d = rnd();
      dv = d[W-1:0];
      // One register per write, so no pin jumps both bits at once
      bus_wr(ofs[op], d);
      case (op)
        0: m_out = dv;
        1: m_dir = dv;
        2: m_out = m_out ^ dv;
        3: m_pu_dis = d[CTRL_PU_DIS_BIT];
        4: m_out = m_out | dv;
        5: m_out = m_out & ~dv;
        6: m_dir = m_dir | dv;
        default: m_dir = m_dir & ~dv;
      endcase
      #1;
      check_pads();
      // Each bus task leaves an idle slot before the next read
      check_regs();
    end
    // Mid-run reset: pins must float again and every bit return to zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    m_out = '0;
    m_dir = '0;
    m_pu_dis = 1'b0;
    check_pads();
    hresetn <= 1'b1;
    check_regs();
    test_done();
  end
endmodule

`default_nettype wire
